// >>> logic/ost_cfg.svh
// Constants of the over-speed trip monitor: register offsets, field
// positions, reset values and timing figures.
// Assumes a 25 MHz control clock and byte addresses on an APB bus.
`ifndef OST_CFG_SVH
`define OST_CFG_SVH

`define OST_ADDR_W         8
`define OST_ADDR_CTRL      8'h00
`define OST_ADDR_THRESH    8'h04
`define OST_ADDR_DELAY     8'h08
`define OST_ADDR_STATUS    8'h0c
`define OST_ADDR_IRQ_STAT  8'h10
`define OST_ADDR_IRQ_CLR   8'h14
`define OST_ADDR_IRQ_EN    8'h18

`define OST_CTRL_INHIBIT   0
`define OST_CTRL_TRIP_CLR  1
`define OST_STAT_TRIPPED   0
`define OST_STAT_OVER      1
`define OST_STAT_ARMED     2
`define OST_IRQ_TRIP       0
`define OST_IRQ_OVER       1
`define OST_IRQ_N          2

// Threshold in units of 0.01 %: default 150.00 %, top 300.00 %.
`define OST_THRESH_W       16
`define OST_THRESH_RST     16'h3a98
`define OST_THRESH_MAX     16'h7530
// Delay in units of 0.01 s: default 0.10 s, top 10.00 s.
`define OST_DELAY_W        10
`define OST_DELAY_RST      10'h00a
`define OST_DELAY_MAX      10'h3e8
`define OST_DELAY_UNIT_NS  10000000
`define OST_CLK_PERIOD_NS  40
`define OST_CYC_PER_UNIT   (`OST_DELAY_UNIT_NS / `OST_CLK_PERIOD_NS)

`endif

// >>> logic/ost_pkg.sv
// Types shared by the over-speed trip monitor files.
// Assumes nothing beyond a SystemVerilog compiler.
package ost_pkg;

  typedef enum logic [1:0] {
    ost_mode_volts_hz,
    ost_mode_sensorless_vec,
    ost_mode_closed_loop_vec,
    ost_mode_pmac
  } ost_mode_e;

  // Speed feedback in units of 0.01 % of full speed, signed.
  typedef struct packed {
    ost_mode_e          mode;
    logic signed [15:0] speed;
  } ost_fb_s;

endpackage

// >>> logic/ost_persist_timer.sv
// Persistence timer: counts clock cycles while the over-speed condition
// holds and reports when the count has gone past the programmed delay.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ost_cfg.svh"

module ost_persist_timer #(
  parameter int unsigned CYC_PER_UNIT = `OST_CYC_PER_UNIT
) (
  input  wire logic                     pclk,     // Control clock.
  input  wire logic                     presetn,  // Async reset, low.
  input  wire logic                     run,      // Condition holds.
  input  wire logic [`OST_DELAY_W-1:0]  delay,    // Delay, 0.01 s units.
  output logic                          expired   // Held past delay.
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] limit;

  // Product fits: 1000 units times 250000 cycles stays below 2^28.
  assign limit = 32'(delay) * 32'(CYC_PER_UNIT);

  always_comb begin
    if (!run) begin
      cnt_d = 32'h0000_0000;
    end else if (cnt_q != 32'hffff_ffff) begin
      cnt_d = cnt_q + 32'h0000_0001;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Strictly longer than the delay: a zero delay still needs two cycles.
  assign expired = run && (cnt_q > limit);

  a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> (cnt_q == 32'h0000_0000))
    else $error("persistence count not restarted");

endmodule
`default_nettype wire

// >>> logic/ost_monitor.sv
// Over-speed trip monitor with an APB register slave and an interrupt.
// Assumes speed feedback and control mode come from the speed loop on
// the same clock, so they are used without synchronisers.
`timescale 1ns/1ps
`default_nettype none
`include "ost_cfg.svh"

module ost_monitor #(
  parameter int unsigned CYC_PER_UNIT = `OST_CYC_PER_UNIT
) (
  input  wire logic                    pclk,     // Control clock, 25 MHz.
  input  wire logic                    presetn,  // Async reset, low.
  input  wire logic                    psel,     // APB select.
  input  wire logic                    penable,  // APB access phase.
  input  wire logic                    pwrite,   // APB write.
  input  wire logic [`OST_ADDR_W-1:0]  paddr,    // APB byte address.
  input  wire logic [31:0]             pwdata,   // APB write data.
  output logic      [31:0]             prdata,   // APB read data.
  output logic                         pready,   // APB ready.
  output logic                         pslverr,  // APB error.
  input  wire ost_pkg::ost_fb_s        fb,       // Speed loop feedback.
  output logic                         tripped,  // Latched trip.
  output logic                         irq       // Level interrupt.
);

  logic                      inhibit_q, inhibit_d;
  logic [`OST_THRESH_W-1:0]  thresh_q, thresh_d;
  logic [`OST_DELAY_W-1:0]   delay_q, delay_d;
  logic                      trip_q, trip_d;
  logic                      over_q, over_d;
  logic [`OST_IRQ_N-1:0]     irq_stat_q, irq_en_q, irq_en_d;
  logic [`OST_IRQ_N-1:0]     irq_set, irq_clr;
  logic [31:0]               rdata_q, rdata_d;
  logic                      err_q, err_d;

  logic        setup;
  logic        wr;
  logic        hit;
  logic        armed;
  logic        over;
  logic        run;
  logic        expired;
  logic        trip_clr;
  logic [16:0] speed_mag;
  logic [16:0] wd17;

  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;

  // The drive may spin either way, so the magnitude is compared.
  assign speed_mag = fb.speed[15] ? (17'h0_0000 - {fb.speed[15], fb.speed})
                                  : {1'b0, fb.speed};
  assign over  = speed_mag > {1'b0, thresh_q};
  assign armed = (fb.mode == ost_pkg::ost_mode_closed_loop_vec) ||
                 (fb.mode == ost_pkg::ost_mode_sensorless_vec);
  assign run   = over && armed && !inhibit_q;

  ost_persist_timer #(
    .CYC_PER_UNIT (CYC_PER_UNIT)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .delay   (delay_q),
    .expired (expired)
  );

  assign trip_clr = wr && (paddr == `OST_ADDR_CTRL) &&
                    pwdata[`OST_CTRL_TRIP_CLR];
  assign wd17 = pwdata[16:0];

  // Settings and trip latch.
  always_comb begin
    inhibit_d = inhibit_q;
    thresh_d  = thresh_q;
    delay_d   = delay_q;
    if (wr && (paddr == `OST_ADDR_CTRL)) begin
      inhibit_d = pwdata[`OST_CTRL_INHIBIT];
    end
    if (wr && (paddr == `OST_ADDR_THRESH)) begin
      if (wd17 > {1'b0, `OST_THRESH_MAX} || pwdata[31:17] != 15'h0000) begin
        thresh_d = `OST_THRESH_MAX;
      end else begin
        thresh_d = pwdata[`OST_THRESH_W-1:0];
      end
    end
    if (wr && (paddr == `OST_ADDR_DELAY)) begin
      if (pwdata > {22'h00_0000, `OST_DELAY_MAX}) begin
        delay_d = `OST_DELAY_MAX;
      end else begin
        delay_d = pwdata[`OST_DELAY_W-1:0];
      end
    end
    // A trip arriving with a software clear still latches.
    if (inhibit_q) begin
      trip_d = 1'b0;
    end else begin
      trip_d = expired || (trip_q && !trip_clr);
    end
    over_d = run;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_q <= 1'b0;
      thresh_q  <= `OST_THRESH_RST;
      delay_q   <= `OST_DELAY_RST;
      trip_q    <= 1'b0;
      over_q    <= 1'b0;
    end else begin
      inhibit_q <= inhibit_d;
      thresh_q  <= thresh_d;
      delay_q   <= delay_d;
      trip_q    <= trip_d;
      over_q    <= over_d;
    end
  end

  assign tripped = trip_q;

  // Interrupt events: trip rising and over-speed condition starting.
  assign irq_set[`OST_IRQ_TRIP] = trip_d && !trip_q;
  assign irq_set[`OST_IRQ_OVER] = run && !over_q;
  assign irq_clr = (wr && (paddr == `OST_ADDR_IRQ_CLR)) ?
                   pwdata[`OST_IRQ_N-1:0] : {`OST_IRQ_N{1'b0}};
  assign irq_en_d = (wr && (paddr == `OST_ADDR_IRQ_EN)) ?
                    pwdata[`OST_IRQ_N-1:0] : irq_en_q;

  genvar gi;
  generate
    for (gi = 0; gi < `OST_IRQ_N; gi = gi + 1) begin : g_irq
      logic sticky_d;
      // Set beats clear so an event in the clearing cycle is kept.
      assign sticky_d = irq_set[gi] || (irq_stat_q[gi] && !irq_clr[gi]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_stat_q[gi] <= 1'b0;
        end else begin
          irq_stat_q[gi] <= sticky_d;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= {`OST_IRQ_N{1'b0}};
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Read data is captured in the setup cycle so the access phase can
  // answer at once from a flip-flop.
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    hit     = 1'b1;
    if (setup) begin
      rdata_d = 32'h0000_0000;
      case (paddr)
        `OST_ADDR_CTRL:     rdata_d[`OST_CTRL_INHIBIT] = inhibit_q;
        `OST_ADDR_THRESH:   rdata_d[`OST_THRESH_W-1:0] = thresh_q;
        `OST_ADDR_DELAY:    rdata_d[`OST_DELAY_W-1:0]  = delay_q;
        `OST_ADDR_STATUS: begin
          rdata_d[`OST_STAT_TRIPPED] = trip_q;
          rdata_d[`OST_STAT_OVER]    = run;
          rdata_d[`OST_STAT_ARMED]   = armed;
        end
        `OST_ADDR_IRQ_STAT: rdata_d[`OST_IRQ_N-1:0] = irq_stat_q;
        `OST_ADDR_IRQ_CLR:  rdata_d = 32'h0000_0000;
        `OST_ADDR_IRQ_EN:   rdata_d[`OST_IRQ_N-1:0] = irq_en_q;
        default:            hit = 1'b0;
      endcase
      err_d = !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = (psel && penable && !pwrite) ? rdata_q : 32'h0000_0000;
  assign pslverr = psel && penable && err_q;

  a_inhibit_no_trip: assert property (@(posedge pclk) disable iff (!presetn)
    inhibit_q |=> !tripped)
    else $error("trip raised while inhibited");

  a_below_thresh_idle: assert property (@(posedge pclk)
    disable iff (!presetn)
    (speed_mag <= {1'b0, thresh_q}) |-> !expired && !run)
    else $error("timer runs at or below threshold");

  a_thresh_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    thresh_q <= `OST_THRESH_MAX)
    else $error("threshold above 300 percent");

  a_trip_after_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(trip_q) |-> $past(run, 1) && $past(run, 2))
    else $error("trip without persistent over-speed");

  a_delay_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    delay_q <= `OST_DELAY_MAX)
    else $error("delay above 10 s");

  a_mode_gates_run: assert property (@(posedge pclk) disable iff (!presetn)
    !armed |-> !run ##1 !$rose(trip_q))
    else $error("trip evaluated outside vector mode");

  a_status_reads_trip: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup && !pwrite && (paddr == `OST_ADDR_STATUS) ##1 (psel && penable)
    |-> prdata[`OST_STAT_TRIPPED] == $past(trip_q))
    else $error("status read disagrees with trip");

  a_restart_on_break: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!over || inhibit_q || !armed) |=> !expired)
    else $error("expiry survives a broken condition");

endmodule
`default_nettype wire

// >>> bench/ost_speed_loop_model.sv
// Model of the drive speed loop that feeds the trip monitor.
// Assumes commands from the bench on the same clock as the monitor.
`timescale 1ns/1ps
`default_nettype none

module ost_speed_loop_model (
  input  wire logic               pclk,       // Control clock.
  input  wire logic               presetn,    // Async reset, low.
  input  wire ost_pkg::ost_mode_e mode_cmd,   // Commanded mode.
  input  wire logic signed [15:0] speed_cmd,  // Commanded speed.
  output var  ost_pkg::ost_fb_s   fb          // Registered feedback.
);
  // The real loop publishes from a register, so feedback lags one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb <= '0;
    end else begin
      fb <= '{mode_cmd, speed_cmd};
    end
  end
endmodule

`default_nettype wire

// >>> bench/ost_monitor_tb_top.sv
// Self-checking bench for the over-speed trip monitor.
// Assumes the monitor answers APB with no wait states.
`timescale 1ns/1ps
`default_nettype none

module ost_monitor_tb_top;
  logic               pclk    = 1'b0;
  logic               presetn = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [7:0]         paddr   = 8'h00;
  logic [31:0]        pwdata  = 32'h0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, tripped, irq, er;
  ost_pkg::ost_mode_e md      = ost_pkg::ost_mode_volts_hz;
  logic signed [15:0] sp      = 16'h0000;
  ost_pkg::ost_fb_s   fb;
  int                 n_fail  = 0;
  int                 checked = 0;
  int                 cyc     = 0;
  localparam ost_pkg::ost_mode_e CL = ost_pkg::ost_mode_closed_loop_vec;

  always #20 pclk = ~pclk;

  ost_speed_loop_model u_ost_speed_loop_model (
    .pclk(pclk), .presetn(presetn), .mode_cmd(md), .speed_cmd(sp), .fb(fb));

  ost_monitor #(.CYC_PER_UNIT(4)) u_ost_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fb(fb), .tripped(tripped),
    .irq(irq));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hang anywhere ends the run here rather than at the simulator limit.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
  endtask

  task automatic set_fb(input ost_pkg::ost_mode_e m, input logic [15:0] s);
    @(posedge pclk);
    md <= m;
    sp <= s;
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_3a98);
    xfer(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_000a);
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(tripped), 32'h0000_0000);
    xfer(1'b0, 8'h1c, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, 8'h04, 32'h0000_9c40);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_7530);
    xfer(1'b1, 8'h08, 32'h0000_03ff);
    xfer(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_03e8);
    $display("test registers done");
    // Threshold 10.00 %, delay 0.02 s, that is 8 cycles here.
    xfer(1'b1, 8'h04, 32'h0000_03e8);
    xfer(1'b1, 8'h08, 32'h0000_0002);
    xfer(1'b1, 8'h18, 32'h0000_0001);
    set_fb(CL, 16'h03e8);
    cyc_wait(20);
    chk(32'(tripped), 32'h0000_0000);
    set_fb(CL, 16'h03e9);
    // Feedback lands one edge late, so the trip comes at the eleventh edge.
    cyc_wait(10);
    chk(32'(tripped), 32'h0000_0000);
    cyc_wait(1);
    chk(32'(tripped), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    xfer(1'b1, 8'h14, 32'h0000_0003);
    cyc_wait(1);
    chk(32'(irq), 32'h0000_0000);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    set_fb(CL, 16'h0000);
    xfer(1'b1, 8'h00, 32'h0000_0002);
    cyc_wait(2);
    chk(32'(tripped), 32'h0000_0000);
    $display("test persistence done");
    for (int k = 0; k < 3; k++) begin
      set_fb(CL, 16'h03e9);
      cyc_wait(6);
      if (k == 0) set_fb(CL, 16'h0000);
      else if (k == 1) set_fb(ost_pkg::ost_mode_volts_hz, 16'h03e9);
      else xfer(1'b1, 8'h00, 32'h0000_0001);
      if (k == 2) xfer(1'b1, 8'h00, 32'h0000_0000);
      else set_fb(CL, 16'h03e9);
      cyc_wait(6);
      chk(32'(tripped), 32'h0000_0000);
      // A restarted count must still run out, ten edges after the condition returns.
      cyc_wait(6);
      chk(32'(tripped), 32'h0000_0001);
      set_fb(CL, 16'h0000);
      xfer(1'b1, 8'h00, 32'h0000_0002);
      cyc_wait(2);
    end
    $display("test restart done");
    xfer(1'b1, 8'h08, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      set_fb(ost_pkg::ost_mode_e'(m[1:0]), 16'hfc17);
      cyc_wait(6);
      chk(32'(tripped), 32'(m == 1 || m == 2));
      set_fb(CL, 16'h0000);
      xfer(1'b1, 8'h00, 32'h0000_0002);
      cyc_wait(2);
    end
    $display("test modes done");
    xfer(1'b1, 8'h14, 32'h0000_0003);
    set_fb(CL, 16'h03e9);
    cyc_wait(6);
    chk(32'(irq), 32'h0000_0001);
    xfer(1'b1, 8'h18, 32'h0000_0000);
    cyc_wait(1);
    chk(32'(irq), 32'h0000_0000);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    cyc_wait(2);
    chk(32'(tripped), 32'h0000_0000);
    cyc_wait(10);
    chk(32'(tripped), 32'h0000_0000);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    cyc_wait(3);
    chk(32'(tripped), 32'h0000_0001);
    $display("test inhibit done");
    // A reset in mid-run drops a standing trip and restores settings.
    @(posedge pclk);
    presetn <= 1'b0;
    cyc_wait(2);
    chk(32'(tripped), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_3a98);
    $display("test reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
